// ==== hw/host_cpu_port.sv ====
// processor slave port: strobe decode, lane steering and cycle-complete handshake
`timescale 1ns/1ps
module host_cpu_port
  import host_port_pkg::*;
#(
  parameter int ACCESS_LATENCY = ACCESS_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_host_word_addr,
  input wire logic [LANE_W-1:0] i_host_lane_addr,
  input wire logic [DATA_W-1:0] i_host_data_lines,
  output logic [DATA_W-1:0] o_host_data_lines,
  output logic o_host_data_lines_oe,
  input wire logic i_host_select_n,
  input wire logic i_host_write_n,
  input wire logic i_host_read_n,
  output logic o_cycle_done_n,
  output logic o_cycle_done_n_oe,
  input wire logic [WIDTH_SEL_W-1:0] i_bus_width_sel,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [ADDR_W-1:0] o_reg_addr,
  output logic [DATA_W-1:0] o_reg_wdata,
  output logic [DATA_W/8-1:0] o_reg_wbe,
  input wire logic [DATA_W-1:0] i_reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int CTRL_W = 3 + WIDTH_SEL_W;
  localparam int BUS_W = ADDR_W + LANE_W + DATA_W;

  logic [CTRL_W-1:0] ctrl_sync;
  logic [BUS_W-1:0] bus_sync;
  logic sel_n;
  logic wr_n;
  logic rd_n;
  logic [WIDTH_SEL_W-1:0] width_code;
  logic [ADDR_W-1:0] word_addr;
  logic [LANE_W-1:0] lane_addr;
  logic [DATA_W-1:0] wr_lines;

  pin_sync #(
    .WIDTH(CTRL_W),
    .RESET_VALUE({3'h7, {WIDTH_SEL_W{1'b0}}})
  ) u_ctrl_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_host_select_n, i_host_write_n, i_host_read_n, i_bus_width_sel}),
    .o_sync(ctrl_sync)
  );

  // bus lines pass the same filter so they settle no later than the strobes
  pin_sync #(
    .WIDTH(BUS_W),
    .RESET_VALUE('0)
  ) u_bus_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_host_word_addr, i_host_lane_addr, i_host_data_lines}),
    .o_sync(bus_sync)
  );

  assign {sel_n, wr_n, rd_n, width_code} = ctrl_sync;
  assign {word_addr, lane_addr, wr_lines} = bus_sync;

  ////////////////////////////////////////////////////////////////////////////
  // width decode and lane steering

  function automatic bus_mode_type decode_width(input logic [WIDTH_SEL_W-1:0] code);
    if (code[WIDTH_UPPER_BIT]) begin
      decode_width = MODE_32_type_v;
    end else if (code == WIDTH_CODE_16) begin
      decode_width = MODE_16_type_v;
    end else begin
      decode_width = MODE_8_type_v;
    end
  endfunction : decode_width

  // byte enables for the register word touched by one access
  function automatic logic [3:0] lane_enables(input bus_mode_type mode,
                                              input logic [LANE_W-1:0] lane);
    unique case (mode)
      MODE_32_type_v: lane_enables = 4'hF;
      MODE_16_type_v: lane_enables = lane[LANE_HALF_BIT] ? 4'hC : 4'h3;
      MODE_8_type_v: lane_enables = 4'h1 << lane;
    endcase
  endfunction : lane_enables

  bus_mode_type mode;
  assign mode = decode_width(width_code);

  logic [DATA_W-1:0] steered_wdata;
  always_comb begin
    steered_wdata = '0;
    unique case (mode)
      MODE_32_type_v: steered_wdata = wr_lines;
      MODE_16_type_v: steered_wdata = {2{wr_lines[15:0]}};
      MODE_8_type_v: steered_wdata = {4{wr_lines[7:0]}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } port_state_type;

  port_state_type state;
  port_state_type next_state;
  logic [ACCESS_CNT_W-1:0] wait_cnt;
  logic [ACCESS_CNT_W-1:0] next_wait_cnt;
  logic is_read;
  logic next_is_read;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] next_addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] next_wdata_q;
  logic [3:0] wbe_q;
  logic [3:0] next_wbe_q;
  logic wr_pulse;
  logic next_wr_pulse;
  logic rd_pulse;
  logic next_rd_pulse;
  logic done;
  logic next_done;

  logic wr_req;
  logic rd_req;
  assign wr_req = !sel_n && !wr_n && rd_n;
  assign rd_req = !sel_n && !rd_n && wr_n;

  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_is_read = is_read;
    next_rd_data = rd_data;
    next_addr_q = addr_q;
    next_wdata_q = wdata_q;
    next_wbe_q = wbe_q;
    next_wr_pulse = 1'b0;
    next_rd_pulse = 1'b0;
    next_done = done;
    unique case (state)
      ST_IDLE: begin
        // both strobes low at once is ambiguous and ignored
        if (wr_req || rd_req) begin
          next_state = ST_WAIT;
          next_is_read = rd_req;
          next_addr_q = word_addr;
          next_wdata_q = steered_wdata;
          next_wbe_q = lane_enables(mode, lane_addr);
          next_wr_pulse = wr_req;
          next_rd_pulse = rd_req;
          next_wait_cnt = ACCESS_CNT_W'(ACCESS_LATENCY);
        end
      end
      ST_WAIT: begin
        if (wait_cnt <= ACCESS_CNT_W'(1)) begin
          next_state = ST_DONE;
          next_done = 1'b1;
          if (is_read) begin
            next_rd_data = i_reg_rdata;
          end
        end else begin
          next_wait_cnt = wait_cnt - ACCESS_CNT_W'(1);
        end
      end
      ST_DONE: begin
        // completion holds until the processor lifts its strobe or select
        if (sel_n || (is_read ? rd_n : wr_n)) begin
          next_state = ST_IDLE;
          next_done = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      is_read <= 1'b0;
      rd_data <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      wbe_q <= '0;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      is_read <= next_is_read;
      rd_data <= next_rd_data;
      addr_q <= next_addr_q;
      wdata_q <= next_wdata_q;
      wbe_q <= next_wbe_q;
      wr_pulse <= next_wr_pulse;
      rd_pulse <= next_rd_pulse;
      done <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read lane steering and pin drive

  logic [DATA_W-1:0] out_lines;
  logic [DATA_W-1:0] next_out_lines;
  logic drive_en;
  logic next_drive_en;

  always_comb begin
    next_out_lines = '0;
    unique case (mode)
      MODE_32_type_v: next_out_lines = rd_data;
      MODE_16_type_v: next_out_lines[15:0] = lane_addr[LANE_HALF_BIT] ?
          rd_data[31:16] : rd_data[15:0];
      MODE_8_type_v: next_out_lines[7:0] = rd_data[8*lane_addr +: 8];
    endcase
    // drive whenever select and the read strobe are low, even if no read access was accepted
    next_drive_en = !sel_n && !rd_n;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_lines <= '0;
      drive_en <= 1'b0;
    end else begin
      out_lines <= next_out_lines;
      drive_en <= next_drive_en;
    end
  end

  // gate with the raw pins too so release is not delayed by the synchroniser
  assign o_host_data_lines = out_lines;
  assign o_host_data_lines_oe = drive_en && !i_host_select_n && !i_host_read_n;

  assign o_cycle_done_n = 1'b0;
  assign o_cycle_done_n_oe = done;

  assign o_reg_wr = wr_pulse;
  assign o_reg_rd = rd_pulse;
  assign o_reg_addr = addr_q;
  assign o_reg_wdata = wdata_q;
  assign o_reg_wbe = wbe_q;

endmodule : host_cpu_port

// ==== include/host_port_pkg.sv ====
// constants and types for the host processor port
package host_port_pkg;

  localparam int ADDR_W = 11;
  localparam int LANE_W = 2;
  localparam int DATA_W = 32;
  localparam int WIDTH_SEL_W = 2;

  localparam logic [1:0] WIDTH_CODE_8 = 2'h0;
  localparam logic [1:0] WIDTH_CODE_16 = 2'h1;
  localparam int WIDTH_UPPER_BIT = 1;

  localparam int LANE_HALF_BIT = 1;
  localparam int SYNC_STAGES = 3;

  // internal register access latency in cycles, counted after request launch
  localparam int ACCESS_CYCLES = 2;
  localparam int ACCESS_CNT_W = 4;

  typedef enum logic [1:0] {
    MODE_8_type_v,
    MODE_16_type_v,
    MODE_32_type_v
  } bus_mode_type;

endpackage : host_port_pkg

// ==== hw/pin_sync.sv ====
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] filtered;
  logic [WIDTH-1:0] next_filtered;

  // a bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_filtered[i] = (stage2[i] == stage3[i]) ? stage3[i] : filtered[i];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      filtered <= RESET_VALUE;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      filtered <= next_filtered;
    end
  end

  assign o_sync = filtered;

endmodule : pin_sync

// ==== bench/host_cpu_port_properties.sv ====
// assertions on the host port pins and register strobes
`timescale 1ns/1ps
module host_cpu_port_checker
  import host_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_host_word_addr,
  input wire logic [LANE_W-1:0] i_host_lane_addr,
  input wire logic [DATA_W-1:0] i_host_data_lines,
  input wire logic o_host_data_lines_oe,
  input wire logic i_host_select_n,
  input wire logic i_host_write_n,
  input wire logic i_host_read_n,
  input wire logic o_cycle_done_n,
  input wire logic o_cycle_done_n_oe,
  input wire logic [WIDTH_SEL_W-1:0] i_bus_width_sel,
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic [ADDR_W-1:0] o_reg_addr,
  input wire logic [DATA_W-1:0] o_reg_wdata,
  input wire logic [DATA_W/8-1:0] o_reg_wbe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_launch; o_reg_wr || o_reg_rd; endsequence
  sequence s_done; o_cycle_done_n_oe && !o_cycle_done_n; endsequence
  property p_done; s_launch |-> ##[1:4] s_done; endproperty
  a_done: assert property (p_done) else $error("no completion after launch");
  property p_od; o_cycle_done_n == 1'b0; endproperty
  a_od: assert property (p_od) else $error("done pin drives high");
  // the raw-pin gate alone would satisfy the first term; the past term needs the register
  property p_oe;
    o_host_data_lines_oe |-> !i_host_select_n && !i_host_read_n
      && $past(!i_host_select_n && !i_host_read_n);
  endproperty
  a_oe: assert property (p_oe) else $error("data driven outside read");
  property p_wr; o_reg_wr |-> !i_host_select_n && !i_host_write_n && i_host_read_n; endproperty
  a_wr: assert property (p_wr) else $error("write without request");
  property p_rd; o_reg_rd |-> !i_host_select_n && !i_host_read_n && i_host_write_n; endproperty
  a_rd: assert property (p_rd) else $error("read without request");
  property p_addr; s_launch |-> o_reg_addr == i_host_word_addr; endproperty
  a_addr: assert property (p_addr) else $error("register address wrong");
  property p_w32;
    o_reg_wr && i_bus_width_sel[1] |-> o_reg_wbe == 4'hF && o_reg_wdata == i_host_data_lines;
  endproperty
  a_w32: assert property (p_w32) else $error("32-bit write lanes wrong");
  property p_w16;
    o_reg_wr && i_bus_width_sel == 2'h1 |-> o_reg_wbe == (i_host_lane_addr[1] ? 4'hC : 4'h3)
      && o_reg_wdata == {2{i_host_data_lines[15:0]}};
  endproperty
  a_w16: assert property (p_w16) else $error("16-bit write lanes wrong");
  property p_w8;
    o_reg_wr && i_bus_width_sel == 2'h0 |-> o_reg_wbe == 4'h1 << i_host_lane_addr
      && o_reg_wdata == {4{i_host_data_lines[7:0]}};
  endproperty
  a_w8: assert property (p_w8) else $error("8-bit write lanes wrong");
  property p_both; (!i_host_write_n && !i_host_read_n) [*8] |-> !(o_reg_wr || o_reg_rd); endproperty
  a_both: assert property (p_both) else $error("access with both strobes");
  property p_nosel; i_host_select_n [*8] |-> !(o_reg_wr || o_reg_rd); endproperty
  a_nosel: assert property (p_nosel) else $error("access without select");
endmodule : host_cpu_port_checker
bind host_cpu_port host_cpu_port_checker i_chk (.*);

// ==== bench/host_cpu_model.sv ====
// processor model driving the host port pins
`timescale 1ns/1ps
module host_cpu_model
  import host_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_done_wire,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic [ADDR_W-1:0] o_addr,
  output logic [LANE_W-1:0] o_lane,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_sel_n,
  output logic o_wr_n,
  output logic o_rd_n
);
  initial begin
    o_addr = '0;
    o_lane = '0;
    o_wdata = '0;
    o_sel_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
  end
  task automatic pins(input logic s, input logic w, input logic r);
    o_sel_n <= s;
    o_wr_n <= w;
    o_rd_n <= r;
  endtask : pins
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [LANE_W-1:0] l,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ok);
    int n;
    n = 0;
    o_addr <= a;
    o_lane <= l;
    o_wdata <= wr ? d : ~d;
    pins(1'b0, !wr, wr);
    // everything held until completion is seen
    do begin @(posedge i_mclk); n++; end while (i_done_wire && n < 40);
    ok = !i_done_wire;
    @(posedge i_mclk);
    q = i_rd_data;
    pins(1'b1, 1'b1, 1'b1);
    while (!i_done_wire && n < 80) begin @(posedge i_mclk); n++; end
    // released address lines carry junk, not the old value; data lines carry ~d and the lane is held
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_mclk);
  endtask : xfer
endmodule : host_cpu_model

// ==== bench/host_cpu_port_bench.sv ====
// self-checking bench for the host processor port
`timescale 1ns/1ps
module host_cpu_port_bench;
  import host_port_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] width = 2'h2;
  logic [DATA_W-1:0] wcap = '0;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  wire [ADDR_W-1:0] addr, reg_addr;
  wire [LANE_W-1:0] lane;
  wire [DATA_W-1:0] wdata, dout, reg_wdata;
  wire [3:0] wbe;
  wire oe, done_n, done_oe, sel_n, wr_n, rd_n, reg_wr, reg_rd;
  wire done_wire = done_oe ? done_n : 1'b1; // external pull-up
  wire [DATA_W-1:0] bus = oe ? dout : ~dout;
  wire [DATA_W-1:0] reg_rdata = 32'h4433_2211 + {21'h0, reg_addr};
  always #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (reg_wr) wcap <= reg_wdata;
  host_cpu_port i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_host_word_addr(addr),
    .i_host_lane_addr(lane), .i_host_data_lines(wdata), .o_host_data_lines(dout),
    .o_host_data_lines_oe(oe), .i_host_select_n(sel_n), .i_host_write_n(wr_n),
    .i_host_read_n(rd_n), .o_cycle_done_n(done_n), .o_cycle_done_n_oe(done_oe),
    .i_bus_width_sel(width), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_wbe(wbe), .i_reg_rdata(reg_rdata));
  host_cpu_model i_cpu (.i_mclk(i_mclk), .i_done_wire(done_wire), .i_rd_data(bus),
    .o_addr(addr), .o_lane(lane), .o_wdata(wdata), .o_sel_n(sel_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [31:0] steer(logic [1:0] w, logic [1:0] l, logic [31:0] r);
    if (w[1]) return r;
    if (w[0]) return l[1] ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
    return {24'h0, r[8*l +: 8]};
  endfunction : steer
  task automatic close_out();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_lanes();
    logic [DATA_W-1:0] q;
    logic ok;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    for (int w = 0; w < 4; w++) begin
      width <= w[1:0];
      repeat (6) @(posedge i_mclk); // straps pass the synchroniser
      for (int l = 0; l < 4; l++) begin
        a = 11'h5A0 + 11'(w * 4 + l);
        d = 32'hF1E2_D3C4 ^ {4{8'(w * 4 + l)}};
        i_cpu.xfer(1'b1, a, l[1:0], d, q, ok);
        check("write done", {31'h0, ok}, 32'h1);
        check("write data", wcap, w[1] ? d : w[0] ? {2{d[15:0]}} : {4{d[7:0]}});
        i_cpu.xfer(1'b0, a, l[1:0], d, q, ok);
        check("read done", {31'h0, ok}, 32'h1);
        check("read data", q, steer(w[1:0], l[1:0], 32'h4433_2211 + {21'h0, a}));
      end
    end
  endtask : t_lanes
  task automatic t_refuse();
    i_cpu.pins(1'b0, 1'b0, 1'b0);
    repeat (20) begin
      @(posedge i_mclk);
      check("both strobes", {31'h0, done_wire}, 32'h1);
    end
    i_cpu.pins(1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge i_mclk);
    i_cpu.pins(1'b1, 1'b1, 1'b0);
    repeat (20) begin
      @(posedge i_mclk);
      check("no select", {30'h0, done_wire, oe}, 32'h2);
    end
    i_cpu.pins(1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge i_mclk);
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    t_lanes();
    t_refuse();
    close_out();
  end
endmodule : host_cpu_port_bench
